// ---- verilog/alarm_irq_pkg.sv ----
// package: shared offsets, bit positions, reset values and types of the alarm block
package alarm_irq_pkg;

  // ----------------------------------------------------------------
  // channel space and register offsets
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 8;
  localparam int CHAN_LSB = 4; // channel index sits at addr[6:4], stride 0x10
  localparam int CHAN_MSB = 6;
  localparam int GLOBAL_SPACE_BIT = 7; // addr[7] set means global space, not ours
  localparam logic [3:0] ENABLE_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h5;
  localparam logic [3:0] CHANGE_OFFSET = 4'h6;

  // ----------------------------------------------------------------
  // bit positions shared by enable, live and change registers
  // ----------------------------------------------------------------
  localparam int BIT_PRBS = 0;
  localparam int BIT_LOSS = 1;
  localparam int BIT_ALL_ONES = 2;
  localparam int BIT_VIOL = 4;
  localparam int BIT_FIFO = 5;
  localparam int BIT_DRIVER = 6;
  localparam int BIT_RSVD = 7;
  localparam logic [7:0] ALARM_BITS_MASK = 8'h77; // bits 7 and 3 unused

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CHANGE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic driver_monitor;
    logic fifo_near_limit;
    logic line_code_violation;
    logic counter_overflow;
    logic all_ones_alarm;
    logic receive_signal_loss;
    logic pseudo_random_pattern;
  } detect_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef enum {REG_NONE, REG_ENABLE, REG_STATUS, REG_CHANGE} reg_sel_t;

  // which channel register an address names
  function automatic reg_sel_t decode_reg(input logic [7:0] addr);
    reg_sel_t sel;
    sel = REG_NONE;
    if (!addr[GLOBAL_SPACE_BIT]) begin
      case (addr[3:0])
        ENABLE_OFFSET: sel = REG_ENABLE;
        STATUS_OFFSET: sel = REG_STATUS;
        CHANGE_OFFSET: sel = REG_CHANGE;
        default: sel = REG_NONE;
      endcase
    end
    return sel;
  endfunction : decode_reg

  // live status byte from one channel's synchronised detectors
  function automatic logic [7:0] live_byte(input detect_t d, input logic count_mode);
    logic [7:0] b;
    b = STATUS_RESET;
    b[BIT_DRIVER] = d.driver_monitor;
    b[BIT_FIFO] = d.fifo_near_limit;
    b[BIT_VIOL] = count_mode ? d.counter_overflow : d.line_code_violation;
    b[BIT_ALL_ONES] = d.all_ones_alarm;
    b[BIT_LOSS] = d.receive_signal_loss;
    b[BIT_PRBS] = d.pseudo_random_pattern;
    return b;
  endfunction : live_byte

endpackage : alarm_irq_pkg

// ---- verilog/level_sync.sv ----
// two-flop synchroniser for a vector of independent level signals
module level_sync
  import alarm_irq_pkg::*;
#(
  parameter int WIDTH = 7
) (
  input wire logic ref_clk, // register clock
  input wire logic reset_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // levels from another domain
  output logic [WIDTH-1:0] sync_out // levels safe to read on ref_clk
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // elaboration refuses an empty vector
  if (WIDTH < 1) begin : g_bad_width
    $error("level_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : level_sync

// ---- verilog/enable_store.sv ----
// per-channel interrupt enable words with a registered read port
module enable_store
  import alarm_irq_pkg::*;
#(
  parameter int DEPTH = NUM_CHAN,
  parameter int AW = 3
) (
  input wire logic ref_clk, // register clock
  input wire logic reset_n, // async reset, active low
  input wire logic wr_en, // write strobe, one cycle
  input wire logic [AW-1:0] wr_addr, // word written
  input wire logic [7:0] wr_data, // data written
  input wire logic [AW-1:0] rd_addr, // word read
  output logic [7:0] rd_data, // registered read data, next cycle
  output logic [DEPTH-1:0][7:0] words // every word, for the gating logic
);

  logic [DEPTH-1:0][7:0] mem_reg;
  logic [DEPTH-1:0][7:0] mem_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;

  // elaboration refuses a depth that the address cannot reach
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("enable_store: DEPTH does not fit AW");
  end

  // write lands in one word; read samples the old content
  always_comb begin
    mem_next = mem_reg;
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem_next[wr_addr] = wr_data;
    end
    rd_next = (int'(rd_addr) < DEPTH) ? mem_reg[rd_addr] : ENABLE_RESET;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_reg <= {DEPTH{ENABLE_RESET}};
      rd_reg <= ENABLE_RESET;
    end else begin
      mem_reg <= mem_next;
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;
  assign words = mem_reg;

endmodule : enable_store

// ---- verilog/alarm_irq_ctrl.sv ----
// alarm live status, change flags and interrupt gating for eight line channels
// Functional notes
// RULE1: enable bit 2 gates all-ones alarm interrupt
// RULE2: enable bit 1 gates signal-loss interrupt
// RULE3: enable bit 0 gates pattern-match interrupt
// RULE4: interrupt pin needs the global enable too
// RULE5: status bit 6 follows driver failure always
// RULE6: driver interrupt needs its enable and global
// RULE7: status bit 5 shows fifo pointers near
// RULE8: bit 4 shows violations, or overflow mode
// RULE9: bit 4 set on violation, bipolar, zeros
// RULE10: violation interrupt needs its enable and global
// RULE11: status bit 2 follows all-ones detection
// RULE12: status bit 1 follows signal loss
// RULE13: status bit 0 follows pattern detection
// RULE14: live bits read-only, zero at reset, 7,3 unused
// RULE15: registers repeat per channel, stride 0x10
// RULE16: any live change sets flag, may interrupt
// RULE17: change flags clear when host reads them
// RULE18: pin ORs enabled flags of all channels
// RULE19: detector inputs synchronised before use
module alarm_irq_ctrl
  import alarm_irq_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN
) (
  input wire logic ref_clk, // register clock, 25 MHz
  input wire logic reset_n, // async reset, active low
  input wire host_req_t host_req, // host strobes, address and write data
  output logic [7:0] rdata, // read data, registered
  output logic rdata_valid, // one-cycle pulse with rdata
  input wire detect_t [CHANNELS-1:0] detect, // raw detector levels per channel
  input wire logic global_irq_en, // global interrupt enable from global space
  input wire logic violation_count_mode, // 1: bit 4 reports counter overflow
  output logic irq_out // interrupt request, active high
);

  localparam int DW = $bits(detect_t);
  localparam int CW = CHAN_MSB - CHAN_LSB + 1;

  // elaboration refuses more channels than addr[6:4] can name
  if (CHANNELS < 1 || CHANNELS > (1 << CW)) begin : g_bad_channels
    $error("alarm_irq_ctrl: bad CHANNELS");
  end

  // ----------------------------------------------------------------
  // detector synchronisation
  // ----------------------------------------------------------------
  logic [CHANNELS*DW-1:0] detect_sync;
  detect_t [CHANNELS-1:0] detect_s;

  // detectors run off line clocks, so every level gets two flops first
  level_sync #(
    .WIDTH(CHANNELS*DW)
  ) u_detect_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in(detect), // RULE19
    .sync_out(detect_sync)
  );

  assign detect_s = detect_sync;

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  reg_sel_t host_sel;
  logic [CW-1:0] host_ch;
  logic ch_ok;
  logic enable_wr;

  // every channel owns the same three offsets, channel index in addr[6:4]
  always_comb begin
    host_sel = decode_reg(host_req.addr); // RULE15
    host_ch = host_req.addr[CHAN_MSB:CHAN_LSB]; // RULE15
    ch_ok = int'(host_ch) < CHANNELS;
    enable_wr = host_req.wr && ch_ok && (host_sel == REG_ENABLE);
  end

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  logic [7:0] enable_rdata;
  logic [CHANNELS-1:0][7:0] enable_words;

  // unused bits are masked on the way in so they always read zero
  enable_store #(
    .DEPTH(CHANNELS),
    .AW(CW)
  ) u_enable_store (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(enable_wr),
    .wr_addr(host_ch),
    .wr_data(host_req.wdata & ALARM_BITS_MASK),
    .rd_addr(host_ch),
    .rd_data(enable_rdata),
    .words(enable_words)
  );

  // ----------------------------------------------------------------
  // live status and change flags
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0][7:0] live_reg;
  logic [CHANNELS-1:0][7:0] live_next;
  logic [CHANNELS-1:0][7:0] flag_reg;
  logic [CHANNELS-1:0][7:0] flag_next;
  logic [CHANNELS-1:0][7:0] change;
  logic [CHANNELS-1:0] flag_clr;

  // live bits track detectors regardless of any enable; a set beats a
  // clear-on-read in the same cycle so no transition is lost
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      live_next[c] = live_byte(detect_s[c], violation_count_mode); // RULE5 RULE7 RULE8 RULE9
      change[c] = (live_next[c] ^ live_reg[c]) & ALARM_BITS_MASK; // RULE16
      flag_clr[c] = host_req.rd && (host_sel == REG_CHANGE) && (int'(host_ch) == c);
      flag_next[c] = (flag_reg[c] & ~(flag_clr[c] ? 8'hff : 8'h00)) | change[c]; // RULE17
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_reg <= {CHANNELS{STATUS_RESET}}; // RULE14
      flag_reg <= {CHANNELS{CHANGE_RESET}};
    end else begin
      live_reg <= live_next; // RULE11 RULE12 RULE13
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  logic [7:0] pend;
  logic irq_reg;
  logic irq_next;

  // per-source pending: any channel with flag and enable both set
  always_comb begin
    pend = 8'h00;
    for (int c = 0; c < CHANNELS; c++) begin
      pend = pend | (flag_reg[c] & enable_words[c]); // RULE1 RULE2 RULE3 RULE6 RULE10
    end
    irq_next = global_irq_en && (|pend); // RULE4 RULE18
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_out = irq_reg;

  // ----------------------------------------------------------------
  // read path: take, then answer two edges later
  // ----------------------------------------------------------------
  reg_sel_t rsel_reg;
  reg_sel_t rsel_next;
  logic rtake_reg;
  logic rtake_next;
  logic [7:0] snap_reg;
  logic [7:0] snap_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // status and flag bytes are snapped at the take edge, so the flags
  // returned are exactly the ones cleared by this read
  always_comb begin
    rtake_next = host_req.rd;
    rsel_next = ch_ok ? host_sel : REG_NONE;
    snap_next = UNMAPPED_READ;
    if (ch_ok && host_sel == REG_STATUS) begin
      snap_next = live_reg[host_ch];
    end else if (ch_ok && host_sel == REG_CHANGE) begin
      snap_next = flag_reg[host_ch];
    end
    rvalid_next = rtake_reg;
    rdata_next = rdata_reg;
    if (rtake_reg) begin
      rdata_next = (rsel_reg == REG_ENABLE) ? enable_rdata : snap_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rtake_reg <= 1'b0;
      rsel_reg <= REG_NONE;
      snap_reg <= UNMAPPED_READ;
      rvalid_reg <= 1'b0;
      rdata_reg <= UNMAPPED_READ;
    end else begin
      rtake_reg <= rtake_next;
      rsel_reg <= rsel_next;
      snap_reg <= snap_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign rdata_valid = rvalid_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_global_gate_off: // RULE4
  assert property (!global_irq_en |=> !irq_out)
    else $error("interrupt raised with global enable clear");

  a_all_ones_gate: // RULE1
  assert property (global_irq_en && pend[BIT_ALL_ONES] |=> irq_out)
    else $error("enabled all-ones change did not interrupt");

  a_loss_gate: // RULE2
  assert property (global_irq_en && pend[BIT_LOSS] |=> irq_out)
    else $error("enabled signal-loss change did not interrupt");

  a_prbs_gate: // RULE3
  assert property (global_irq_en && pend[BIT_PRBS] |=> irq_out)
    else $error("enabled pattern change did not interrupt");

  a_driver_viol_gate: // RULE6
  assert property (global_irq_en && (pend[BIT_DRIVER] || pend[BIT_VIOL]) |=> irq_out)
    else $error("enabled driver or violation change did not interrupt");

  a_viol_gate: // RULE10
  assert property (global_irq_en && pend[BIT_VIOL] |=> irq_out)
    else $error("enabled violation change did not interrupt");

  a_fifo_gate: // RULE18
  assert property (global_irq_en && pend[BIT_FIFO] |=> irq_out)
    else $error("enabled fifo limit change did not interrupt");

  a_irq_masked_off: // RULE18
  assert property (irq_out == ($past(global_irq_en) && (|$past(pend))))
    else $error("interrupt pin does not match enabled pending flags");

  a_no_pend_quiet: // RULE18
  assert property (!(|pend) |=> !irq_out)
    else $error("interrupt raised with nothing pending and enabled");

  a_change_sets_flag: // RULE16
  assert property ((|change[0]) |=> ((flag_reg[0] & $past(change[0])) == $past(change[0])))
    else $error("live change did not set its flag");

  a_read_clears_flag: // RULE17
  assert property (flag_clr[0] && !(|change[0]) |=> flag_reg[0] == 8'h00)
    else $error("change flags not cleared by read");

  a_viol_mode_select: // RULE8
  assert property (##1 live_reg[0][BIT_VIOL] == ($past(violation_count_mode)
      ? $past(detect_s[0].counter_overflow) : $past(detect_s[0].line_code_violation)))
    else $error("violation bit follows wrong source");

  a_unused_bits_zero: // RULE14
  assert property (rdata_valid |-> (rdata[BIT_RSVD] == 1'b0 && rdata[3] == 1'b0))
    else $error("unused bit read as one");

  a_read_latency: // RULE15
  assert property (host_req.rd |-> ##2 rdata_valid)
    else $error("read answer not two cycles after take");

  a_valid_after_read: // RULE15
  assert property (rdata_valid |-> $past(host_req.rd, 2))
    else $error("read answer without a read two edges earlier");

  a_enable_write: // RULE15
  assert property (enable_wr && (host_ch == '0)
      |=> enable_words[0] == ($past(host_req.wdata) & ALARM_BITS_MASK))
    else $error("enable write did not land in its channel word");

  // live mapping is watched on channel 0; every channel runs the same function
  a_driver_live: // RULE5
  assert property (##1 live_reg[0][BIT_DRIVER] == $past(detect_s[0].driver_monitor))
    else $error("driver status bit does not follow its detector");

  a_fifo_live: // RULE7
  assert property (##1 live_reg[0][BIT_FIFO] == $past(detect_s[0].fifo_near_limit))
    else $error("fifo status bit does not follow its detector");

  a_all_ones_live: // RULE11
  assert property (##1 live_reg[0][BIT_ALL_ONES] == $past(detect_s[0].all_ones_alarm))
    else $error("all-ones status bit does not follow its detector");

  a_loss_live: // RULE12
  assert property (##1 live_reg[0][BIT_LOSS] == $past(detect_s[0].receive_signal_loss))
    else $error("signal-loss status bit does not follow its detector");

  a_prbs_live: // RULE13
  assert property (##1 live_reg[0][BIT_PRBS] == $past(detect_s[0].pseudo_random_pattern))
    else $error("pattern status bit does not follow its detector");

  a_spare_bits_zero: // RULE14
  assert property (((live_reg[0] | flag_reg[0]) & ~ALARM_BITS_MASK) == 8'h00)
    else $error("unused live or flag bit set");

  // two flops exactly: a detector level reaches the synced copy two edges later
  a_sync_depth: // RULE19
  assert property (##2 detect_s[0] == $past(detect[0], 2))
    else $error("detector level not delayed by two flops");

  a_last_flag_set: // RULE16
  assert property ((|change[CHANNELS-1]) |=>
      ((flag_reg[CHANNELS-1] & $past(change[CHANNELS-1])) == $past(change[CHANNELS-1])))
    else $error("live change on last channel did not set its flag");

endmodule : alarm_irq_ctrl

// ---- dv/tb_alarm_irq_ctrl.sv ----
// testbench: register access, live status and interrupt gating of the alarm block
module tb_alarm_irq_ctrl
  import alarm_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and device under test
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  host_req_t host_req = '0;
  logic [7:0] rdata;
  logic rdata_valid;
  detect_t [NUM_CHAN-1:0] detect = '0;
  logic global_irq_en = 1'b1;
  logic violation_count_mode = 1'b0;
  logic irq_out;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  alarm_irq_ctrl #(.CHANNELS(NUM_CHAN)) i_dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .host_req(host_req),
    .rdata(rdata),
    .rdata_valid(rdata_valid),
    .detect(detect),
    .global_irq_en(global_irq_en),
    .violation_count_mode(violation_count_mode),
    .irq_out(irq_out)
  );

  // 25 MHz register clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers: compares, bus cycles, waits
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit

  function automatic logic [7:0] addr_of(input int ch, input logic [3:0] off);
    return {1'b0, ch[2:0], off};
  endfunction : addr_of

  // write strobe stands for exactly one rising edge
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge ref_clk);
    host_req.wr = 1'b0;
  endtask : reg_wr

  // valid stands only between the first and second edge after the take edge,
  // so it is sampled at the falling edge inside that cycle
  task automatic reg_rd(input logic [7:0] addr, output logic [7:0] got);
    @(negedge ref_clk);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge ref_clk);
    host_req.rd = 1'b0;
    @(negedge ref_clk);
    chk_bit(rdata_valid, 1'b1);
    got = rdata;
  endtask : reg_rd

  task automatic wait_edges(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_edges

  // detector levels change off the sampling edge
  task automatic set_det(input int ch, input int idx, input logic val);
    @(negedge ref_clk);
    detect[ch][idx] = val;
  endtask : set_det

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] v;
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      for (int off = 4; off < 7; off++) begin
        reg_rd(addr_of(ch, off[3:0]), v);
        chk_byte(v, 8'h00);
      end
    end
    chk_bit(irq_out, 1'b0);
  endtask : t_reset_values

  // all words written first so that aliasing between channels shows on readback
  task automatic t_enable_rw();
    logic [7:0] v;
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      reg_wr(addr_of(ch, 4'h4), {1'b1, ch[2:0], 1'b1, ch[2:0]});
    end
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      reg_rd(addr_of(ch, 4'h4), v);
      chk_byte(v, {1'b1, ch[2:0], 1'b1, ch[2:0]} & 8'h77);
      reg_wr(addr_of(ch, 4'h5), 8'hff);
      reg_rd(addr_of(ch, 4'h5), v);
      chk_byte(v, 8'h00);
      reg_wr(addr_of(ch, 4'h4), 8'h00);
    end
    reg_rd(8'h84, v);
    chk_byte(v, 8'h00);
    reg_rd(8'h07, v);
    chk_byte(v, 8'h00);
  endtask : t_enable_rw

  // every live source on every channel: raise, flag, clear, fall while masked
  task automatic t_live_and_irq();
    int bits[6] = '{0, 1, 2, 4, 5, 6};
    logic [7:0] v;
    logic [7:0] m;
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      foreach (bits[i]) begin
        m = 8'h01 << bits[i];
        reg_wr(addr_of(ch, 4'h4), m);
        set_det(ch, bits[i], 1'b1);
        wait_edges(5);
        chk_bit(irq_out, 1'b1);
        reg_rd(addr_of(ch, 4'h5), v);
        chk_byte(v, m);
        reg_rd(addr_of(ch, 4'h6), v);
        chk_byte(v, m);
        chk_bit(irq_out, 1'b0);
        reg_wr(addr_of(ch, 4'h4), 8'h00);
        set_det(ch, bits[i], 1'b0);
        wait_edges(5);
        chk_bit(irq_out, 1'b0);
        reg_rd(addr_of(ch, 4'h6), v);
        chk_byte(v, m);
        reg_rd(addr_of(ch, 4'h6), v);
        chk_byte(v, 8'h00);
      end
    end
  endtask : t_live_and_irq

  // a pending enabled flag must still wait for the global enable
  task automatic t_global();
    logic [7:0] v;
    global_irq_en = 1'b0;
    reg_wr(addr_of(3, 4'h4), 8'h02);
    set_det(3, 1, 1'b1);
    wait_edges(5);
    chk_bit(irq_out, 1'b0);
    @(negedge ref_clk);
    global_irq_en = 1'b1;
    wait_edges(2);
    chk_bit(irq_out, 1'b1);
    @(negedge ref_clk);
    global_irq_en = 1'b0;
    wait_edges(2);
    chk_bit(irq_out, 1'b0);
    @(negedge ref_clk);
    global_irq_en = 1'b1;
    set_det(3, 1, 1'b0);
    reg_wr(addr_of(3, 4'h4), 8'h00);
    wait_edges(5);
    reg_rd(addr_of(3, 4'h6), v);
    chk_byte(v, 8'h02);
  endtask : t_global

  // bit 4 source follows the mode: violation activity or counter overflow
  task automatic t_count_mode();
    logic [7:0] v;
    set_det(2, 3, 1'b1);
    wait_edges(5);
    reg_rd(addr_of(2, 4'h5), v);
    chk_byte(v, 8'h00);
    violation_count_mode = 1'b1;
    wait_edges(5);
    reg_rd(addr_of(2, 4'h5), v);
    chk_byte(v, 8'h10);
    reg_rd(addr_of(2, 4'h6), v);
    chk_byte(v, 8'h10);
    set_det(2, 3, 1'b0);
    detect[2][4] = 1'b1;
    wait_edges(5);
    reg_rd(addr_of(2, 4'h5), v);
    chk_byte(v, 8'h00);
    @(negedge ref_clk);
    violation_count_mode = 1'b0;
    wait_edges(5);
    reg_rd(addr_of(2, 4'h5), v);
    chk_byte(v, 8'h10);
    set_det(2, 4, 1'b0);
    wait_edges(5);
    reg_rd(addr_of(2, 4'h6), v);
    chk_byte(v, 8'h10);
  endtask : t_count_mode

  // reset in mid-run drops a live interrupt and the enable word
  task automatic t_mid_reset();
    logic [7:0] v;
    reg_wr(addr_of(1, 4'h4), 8'h01);
    set_det(1, 0, 1'b1);
    wait_edges(5);
    chk_bit(irq_out, 1'b1);
    @(negedge ref_clk);
    reset_n = 1'b0;
    detect[1][0] = 1'b0;
    wait_edges(2);
    chk_bit(irq_out, 1'b0);
    @(negedge ref_clk);
    reset_n = 1'b1;
    reg_rd(addr_of(1, 4'h4), v);
    chk_byte(v, 8'h00);
  endtask : t_mid_reset

  // ----------------------------------------------------------------
  // closing report, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // the whole sequence needs about 1500 cycles; a hang is cut well above that
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset_values();
    t_enable_rw();
    t_live_and_irq();
    t_global();
    t_count_mode();
    t_mid_reset();
    tally_and_finish();
  end

endmodule : tb_alarm_irq_ctrl
